// >>> bench/ref_source_model.sv
`timescale 1ns/1ps
module ref_source_model (
  input  wire  en_primary,          // Primary source running
  input  wire  en_secondary,        // Secondary source running
  output logic ref_input_primary,   // Primary reference
  output logic ref_input_secondary  // Secondary reference
);
  // 80 ns period, phase unrelated to clk; a dead source rests low
  initial begin
    ref_input_primary = 1'b0;
    #3;
    forever #40 ref_input_primary = en_primary & ~ref_input_primary;
  end
  // Second source, offset so the two edges never coincide
  initial begin
    ref_input_secondary = 1'b0;
    #7;
    forever #40 ref_input_secondary = en_secondary & ~ref_input_secondary;
  end
endmodule

// >>> bench/ref_switchover_pll_ctrl_sva.sv
`timescale 1ns/1ps
`include "ref_switchover_consts.vh"
module ref_ctrl_sva (
  input wire       clk,                   // Clock
  input wire       rst,                   // Reset
  input wire       psel,                  // Select
  input wire       penable,               // Access
  input wire       pready,                // Ready
  input wire       cmos_primary,          // CMOS mode
  input wire       diff_pd_primary,       // Diff rx off
  input wire       se_pd_primary,         // SE buffer off
  input wire       osc_rx_pd,             // Loop off
  input wire       present_primary,       // Primary seen
  input wire       present_secondary,     // Secondary seen
  input wire       active_secondary,      // Secondary active
  input wire       holdover,              // Holdover
  input wire       cp_tristate,           // Pump open
  input wire       cp_half_supply,        // Pump mid-rail
  input wire       loop_resync,           // Resync pulse
  input wire [2:0] vco_divider_one_ratio, // Divider ratio
  input wire       vco_cal_start,         // Cal start
  input wire       vco_cal_busy           // Cal running
);
  localparam int CAL_N = `CAL_CYCLES;
  reg [2:0] up_q;
  reg [8:0] busy_n_q;

  // ****
  // Helper counters: the holdover check starts late after reset
  // ****
  always @(posedge clk) begin
    if (rst) begin
      up_q     <= 3'h0;
      busy_n_q <= 9'h000;
    end else begin
      if (up_q != 3'h7)
        up_q <= up_q + 3'h1;
      busy_n_q <= vco_cal_busy ? busy_n_q + 9'h001 : 9'h000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Properties
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("ready late");
  diff_off_a: assert property (
    diff_pd_primary == (osc_rx_pd | cmos_primary)) else $error("diff rx");
  se_off_a: assert property (
    osc_rx_pd || !cmos_primary |-> se_pd_primary) else $error("se buffer");
  hold_entry_a: assert property (
    up_q == 3'h7 && !present_primary && !present_secondary |=> holdover)
    else $error("no holdover");
  hold_exit_a: assert property (
    present_primary || present_secondary |=> !holdover) else $error("stuck");
  pump_mode_a: assert property (
    holdover == (cp_tristate ^ cp_half_supply)) else $error("pump mode");
  resync_a: assert property (
    $fell(holdover) |-> ##[0:1] loop_resync) else $error("no resync");
  vco_ratio_a: assert property (
    vco_divider_one_ratio inside {3'h3, 3'h4, 3'h5}) else $error("ratio");
  cal_start_a: assert property (
    vco_cal_start == $rose(vco_cal_busy)) else $error("cal start");
  cal_length_a: assert property (
    $fell(vco_cal_busy) |-> busy_n_q == CAL_N) else $error("cal length");
  cover property ($fell(holdover));
  cover property ($rose(active_secondary));
  cover property (vco_cal_start);
endmodule

bind ref_switchover_pll_ctrl ref_ctrl_sva chk_u (.*);

// >>> bench/ref_switchover_pll_ctrl_test.sv
`timescale 1ns/1ps
`include "ref_switchover_consts.vh"
module ref_switchover_pll_ctrl_test;
  logic        clk, rst, psel, penable, pwrite, ref_select_pin, e;
  logic [31:0] paddr, pwdata, prdata, r;
  logic        pready, pslverr, ref_input_primary, ref_input_secondary;
  logic        cmos_primary, cmos_secondary, diff_pd_primary, p, sp, ss;
  logic        diff_pd_secondary, se_pd_primary, se_pd_secondary;
  logic        osc_rx_pd, div_pulse_primary, div_pulse_secondary;
  logic        present_primary, present_secondary, active_secondary;
  logic        holdover, cp_tristate, cp_half_supply, loop_resync;
  logic        vco_cal_start, vco_cal_busy, en_p, en_s;
  logic [1:0]  osc_rx_cfg;
  logic [7:0]  fb_ratio, v;
  logic [2:0]  vco_divider_one_ratio, vco_divider_two_ratio;
  logic [15:0] lfsr_q;
  int          errors, checks, i, c, a, mdl[1024];

  ref_switchover_pll_ctrl dut_u (.*);
  ref_source_model src_u (.en_primary(en_p), .en_secondary(en_s),
    .ref_input_primary(ref_input_primary),
    .ref_input_secondary(ref_input_secondary));

  // ****
  // Clock, watchdog, helpers
  // ****
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Run needs about 22k cycles; 50k is ample
  initial begin
    #500000;
    errors++;
    tally_and_finish;
  end

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Setup, access held until ready, then release and one idle edge
  task apb(input logic w, input logic [9:0] x, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {20'h00000, x, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [9:0] x, input int d);
    apb(1'b1, x, d);
    mdl[x] = d;
  endtask
  task rd(input logic [9:0] x, input logic [31:0] m);
    apb(1'b0, x, 32'h0);
    chk(r & m, mdl[x] & m);
  endtask
  // Shadow copy reaches the outputs two edges after the write
  task apply;
    wr(`IDX_APPLY, 1);
    idle(4);
  endtask
  task gap(input logic s, input int exp);
    int g;
    g = 0;
    while ((s ? div_pulse_secondary : div_pulse_primary) !== 1'b1
           && g < 9000) begin
      @(posedge clk);
      g++;
    end
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while ((s ? div_pulse_secondary : div_pulse_primary) !== 1'b1
               && g < 9000);
    chk(g, exp);
  endtask
  task tally_and_finish;
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst, en_p, en_s} = 3'b111;
    {psel, penable, pwrite, ref_select_pin, paddr, pwdata} = '0;
    lfsr_q = 16'hB5D9;
    mdl[`IDX_SWITCH_CTRL] = 1;
    mdl[`IDX_FEEDBACK] = 3;
    idle(4);
    rst <= 1'b0;
    @(posedge clk);
    chk(fb_ratio, 8'h0C);
    rd(`IDX_SWITCH_CTRL, 32'hFF);
    rd(`IDX_FEEDBACK, 32'h3FF);
    apb(1'b0, 10'h3FF, 32'h0);
    chk({e, r[30:0]}, 32'h80000000);
    for (i = 0; i < 6; i++) begin
      lfsr_q = step(lfsr_q);
      v = lfsr_q[7:0] & 8'h63;
      {ss, sp, p} = lfsr_q[10:8];
      wr(`IDX_INPUT_CFG, v);
      wr(`IDX_POWER, {p, 2'b00});
      wr(`IDX_SWITCH_CTRL, {ss, sp, 4'h1});
      apply;
      chk(cmos_primary, v[5]);
      chk(cmos_secondary, v[6]);
      chk(osc_rx_cfg, v[1:0]);
      chk(osc_rx_pd, p);
      chk(diff_pd_primary, {p | v[5]});
      chk(diff_pd_secondary, {p | v[6]});
      chk(se_pd_primary, {p | sp | ~v[5]});
      chk(se_pd_secondary, {p | ss | ~v[6]});
      rd(`IDX_INPUT_CFG, 32'hFF);
    end
    wr(`IDX_POWER, 0);
    wr(`IDX_SWITCH_CTRL, 1);
    wr(`IDX_DIV_PRIMARY, 3);
    wr(`IDX_DIV_SECONDARY, 1023);
    apply;
    gap(1'b0, 24);
    gap(1'b1, 24);
    wr(`IDX_REF_MISC, 8'h80);
    apply;
    gap(1'b1, 8184);
    wr(`IDX_DIV_SECONDARY, 2);
    apply;
    idle(100);
    chk(active_secondary, 0);
    en_p <= 1'b0;
    idle(1100);
    chk({present_primary, active_secondary}, 1);
    en_p <= 1'b1;
    idle(100);
    chk(active_secondary, 1);
    en_s <= 1'b0;
    idle(1100);
    chk({present_secondary, active_secondary}, 0);
    en_s <= 1'b1;
    wr(`IDX_SWITCH_CTRL, 3);
    apply;
    en_p <= 1'b0;
    idle(1100);
    chk(active_secondary, 1);
    en_p <= 1'b1;
    idle(100);
    chk(active_secondary, 0);
    wr(`IDX_REF_MISC, 8'hC0);
    apply;
    {en_p, en_s} <= 2'b00;
    idle(1100);
    chk({holdover, cp_half_supply, cp_tristate}, 6);
    wr(`IDX_REF_MISC, 8'h80);
    apply;
    chk({holdover, cp_half_supply, cp_tristate}, 5);
    {en_p, en_s} <= 2'b11;
    idle(100);
    chk(holdover, 0);
    wr(`IDX_SWITCH_CTRL, 4);
    apply;
    chk(active_secondary, 1);
    wr(`IDX_SWITCH_CTRL, 8);
    apply;
    chk(active_secondary, 0);
    ref_select_pin <= 1'b1;
    idle(5);
    chk(active_secondary, 1);
    for (i = 0; i < 4; i++) begin
      lfsr_q = step(lfsr_q);
      c = i == 0 ? 63 : 3 + int'(lfsr_q) % 61;
      a = i == 0 ? 3 : int'(lfsr_q[1:0]);
      wr(`IDX_FEEDBACK, a * 256 + c);
      apply;
      chk(fb_ratio, 4 * c + a);
    end
    for (i = 0; i < 3; i++) begin
      wr(`IDX_VCO_DIV, i + 4 * (2 - i));
      apply;
      chk({vco_divider_one_ratio, vco_divider_two_ratio}, 7 * i + 29);
    end
    apb(1'b1, `IDX_VCO_DIV, 32'hF);
    apply;
    chk({vco_divider_one_ratio, vco_divider_two_ratio}, 6'o53);
    wr(`IDX_VCO_CTRL, 2);
    apply;
    mdl[`IDX_STATUS] = 1;
    rd(`IDX_STATUS, 1);
    idle(250);
    mdl[`IDX_STATUS] = 0;
    rd(`IDX_STATUS, 1);
    apply;
    chk(vco_cal_busy, 0);
    wr(`IDX_VCO_CTRL, 0);
    apply;
    wr(`IDX_VCO_CTRL, 2);
    apply;
    chk(vco_cal_busy, 1);
    tally_and_finish;
  end
endmodule

// >>> verilog/ref_switchover_consts.vh
`ifndef REF_SWITCHOVER_CONSTS_VH
`define REF_SWITCHOVER_CONSTS_VH

// ****************************************************
// Register indices (byte address is four times these)
// ****************************************************
`define IDX_DIV_PRIMARY   10'h014
`define IDX_DIV_SECONDARY 10'h016
`define IDX_INPUT_CFG     10'h01A
`define IDX_REF_MISC      10'h01C
`define IDX_SWITCH_CTRL   10'h01D
`define IDX_FEEDBACK      10'h0F0
`define IDX_VCO_DIV       10'h0F1
`define IDX_VCO_CTRL      10'h0F3
`define IDX_STATUS        10'h22D
`define IDX_POWER         10'h233
`define IDX_APPLY         10'h234

// ****************************************************
// Field positions
// ****************************************************
`define BIT_OSC_CFG_LO    0
`define BIT_CMOS_PRIMARY  5
`define BIT_CMOS_SECOND   6
`define BIT_HOLD_HALF     6
`define BIT_INDEP_DIV     7
`define BIT_AUTO_EN       0
`define BIT_REVERTIVE     1
`define BIT_MANUAL_SEC    2
`define BIT_USE_PIN       3
`define BIT_SE_PD_PRIMARY 4
`define BIT_SE_PD_SECOND  5
`define BIT_CAL_VCO       1
`define BIT_LOOP_PD       2
`define BIT_APPLY         0
`define FB_SWALLOW_LO     8
`define VCO_DIV2_LO       2

// ****************************************************
// Reset values
// ****************************************************
`define RST_DIV           10'h001
`define RST_INPUT_CFG     8'h00
`define RST_REF_MISC      8'h00
`define RST_SWITCH_CTRL   8'h01
`define RST_FB_COARSE     6'h03
`define RST_FB_SWALLOW    2'h0
`define RST_VCO_DIV_CODE  2'h0

// ****************************************************
// Timing
// ****************************************************
`define CLK_PERIOD_NS     10
`define LOSS_TIME_NS      10000
// Cycle counts: the times at the clock period, sized for 16-bit counters
`define LOSS_CYCLES       16'h03E8
`define CAL_TIME_NS       2000
`define CAL_CYCLES        16'h00C8

`endif

// >>> verilog/ref_switchover_pll_ctrl.v
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "ref_switchover_consts.vh"

module ref_switchover_pll_ctrl (
  input  wire        clk,                   // 100 MHz system clock
  input  wire        rst,                   // Synchronous reset, high
  input  wire        psel,                  // APB select
  input  wire        penable,               // APB access phase
  input  wire        pwrite,                // APB write
  input  wire [31:0] paddr,                 // APB byte address
  input  wire [31:0] pwdata,                // APB write data
  output wire [31:0] prdata,                // APB read data
  output wire        pready,                // APB ready
  output wire        pslverr,               // APB error, unmapped
  input  wire        ref_input_primary,     // Primary reference pin
  input  wire        ref_input_secondary,   // Secondary reference pin
  input  wire        ref_select_pin,        // Manual select, 1 = second
  output wire        cmos_primary,          // Primary in CMOS mode
  output wire        cmos_secondary,        // Secondary in CMOS mode
  output wire        diff_pd_primary,       // Primary diff rx off
  output wire        diff_pd_secondary,     // Secondary diff rx off
  output wire        se_pd_primary,         // Primary SE buffer off
  output wire        se_pd_secondary,       // Secondary SE buffer off
  output wire [1:0]  osc_rx_cfg,            // Oscillator rx config
  output wire        osc_rx_pd,             // Oscillator rx off
  output wire        div_pulse_primary,     // Prescaled primary pulse
  output wire        div_pulse_secondary,   // Prescaled second pulse
  output wire        present_primary,       // Primary seen by monitor
  output wire        present_secondary,     // Secondary seen
  output wire        active_secondary,      // Active ref is secondary
  output wire        holdover,              // In holdover
  output wire        cp_tristate,           // Input pump tristated
  output wire        cp_half_supply,        // Input pump at mid-rail
  output wire        loop_resync,           // Resync pulse, one cycle
  output wire [7:0]  fb_ratio,              // Output-loop feedback N
  output wire [2:0]  vco_divider_one_ratio, // First VCO divider
  output wire [2:0]  vco_divider_two_ratio, // Second VCO divider
  output wire        vco_cal_start,         // Calibration start pulse
  output wire        vco_cal_busy           // Calibration running
);
  // ****************************************************
  // Declarations
  // ****************************************************
  localparam [15:0] LOSS_CNT = `LOSS_CYCLES;
  localparam [15:0] CAL_CNT  = `CAL_CYCLES;
  wire [9:0]  idx;
  wire [9:0]  ratio [0:1];
  wire        setup_ph, wr_ok, manual_sec;
  reg         mapped, next_sec, pready_q, pslverr_q, sel_s1_q, sel_s2_q;
  reg  [31:0] rd_mux, prdata_q;
  // Shadows take writes; active copies load together on apply
  reg  [9:0]  div_p_sh_q, div_s_sh_q, div_p_q, div_s_q;
  reg  [7:0]  in_cfg_sh_q, misc_sh_q, sw_sh_q, in_cfg_q, misc_q, sw_q;
  reg  [5:0]  coarse_sh_q, coarse_q;
  reg  [1:0]  swallow_sh_q, m1_sh_q, m2_sh_q, swallow_q, m1_q, m2_q;
  reg         cal_sh_q, loop_pd_sh_q, apply_q, cal_q, loop_pd_q;
  reg  [1:0]  ref_s1_q, ref_s2_q, ref_s3_q, div_pulse_q, present_q, cfg_out_q;
  reg  [2:0]  m1_ratio_q, m2_ratio_q;
  reg  [7:0]  fb_q;
  reg  [15:0] cal_cnt_q;
  reg         active_sec_q, holdover_q, resync_q, cp_tri_q, cp_half_q;
  reg         cmos_p_q, cmos_s_q, dpd_p_q, dpd_s_q, spd_p_q, spd_s_q;
  reg         osc_pd_q, cal_prev_q, cal_start_q, cal_busy_q;

  // ****************************************************
  // APB slave: setup cycle prepares the answer
  // ****************************************************
  assign idx      = paddr[11:2];
  assign setup_ph = psel & ~penable;
  assign wr_ok    = psel & penable & pready_q & pwrite & mapped;

  // Decode and read mux; reads return the shadow values, status returns the live state
  always @* begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (idx)
      `IDX_DIV_PRIMARY:   rd_mux[9:0] = div_p_sh_q;
      `IDX_DIV_SECONDARY: rd_mux[9:0] = div_s_sh_q;
      `IDX_INPUT_CFG:     rd_mux[7:0] = in_cfg_sh_q;
      `IDX_REF_MISC:      rd_mux[7:0] = misc_sh_q;
      `IDX_SWITCH_CTRL:   rd_mux[7:0] = sw_sh_q;
      `IDX_FEEDBACK: begin
        rd_mux[5:0]                 = coarse_sh_q;
        rd_mux[`FB_SWALLOW_LO+1:`FB_SWALLOW_LO] = swallow_sh_q;
      end
      `IDX_VCO_DIV: begin
        rd_mux[1:0]                 = m1_sh_q;
        rd_mux[`VCO_DIV2_LO+1:`VCO_DIV2_LO] = m2_sh_q;
      end
      `IDX_VCO_CTRL:      rd_mux[`BIT_CAL_VCO] = cal_sh_q;
      `IDX_STATUS: begin
        rd_mux[0] = cal_busy_q;
        rd_mux[1] = active_sec_q;
        rd_mux[2] = holdover_q;
        rd_mux[3] = present_q[0];
        rd_mux[4] = present_q[1];
      end
      `IDX_POWER:         rd_mux[`BIT_LOOP_PD] = loop_pd_sh_q;
      `IDX_APPLY:         rd_mux = 32'h0000_0000;
      default:            mapped = 1'b0;
    endcase
  end

  // Answer in the first access cycle, no wait states
  always @(posedge clk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & ~mapped;
      if (setup_ph)
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // Shadow register writes; the apply register self-clears
  always @(posedge clk) begin
    if (rst) begin
      div_p_sh_q   <= `RST_DIV;
      div_s_sh_q   <= `RST_DIV;
      in_cfg_sh_q  <= `RST_INPUT_CFG;
      misc_sh_q    <= `RST_REF_MISC;
      sw_sh_q      <= `RST_SWITCH_CTRL;
      coarse_sh_q  <= `RST_FB_COARSE;
      swallow_sh_q <= `RST_FB_SWALLOW;
      m1_sh_q      <= `RST_VCO_DIV_CODE;
      m2_sh_q      <= `RST_VCO_DIV_CODE;
      cal_sh_q     <= 1'b0;
      loop_pd_sh_q <= 1'b0;
      apply_q      <= 1'b0;
    end else begin
      apply_q <= wr_ok & (idx == `IDX_APPLY) & pwdata[`BIT_APPLY];
      if (wr_ok) begin
        case (idx)
          `IDX_DIV_PRIMARY:   div_p_sh_q  <= pwdata[9:0];
          `IDX_DIV_SECONDARY: div_s_sh_q  <= pwdata[9:0];
          `IDX_INPUT_CFG:     in_cfg_sh_q <= pwdata[7:0];
          `IDX_REF_MISC:      misc_sh_q   <= pwdata[7:0];
          `IDX_SWITCH_CTRL:   sw_sh_q     <= pwdata[7:0];
          `IDX_FEEDBACK: begin
            coarse_sh_q  <= pwdata[5:0];
            swallow_sh_q <= pwdata[`FB_SWALLOW_LO+1:`FB_SWALLOW_LO];
          end
          `IDX_VCO_DIV: begin
            // Code 3 has no ratio, so it is not stored
            if (pwdata[1:0] != 2'h3)
              m1_sh_q <= pwdata[1:0];
            if (pwdata[`VCO_DIV2_LO+1:`VCO_DIV2_LO] != 2'h3)
              m2_sh_q <= pwdata[`VCO_DIV2_LO+1:`VCO_DIV2_LO];
          end
          `IDX_VCO_CTRL:      cal_sh_q     <= pwdata[`BIT_CAL_VCO];
          `IDX_POWER:         loop_pd_sh_q <= pwdata[`BIT_LOOP_PD];
          default: ;
        endcase
      end
    end
  end

  // Apply strobe moves every shadow into the working set
  always @(posedge clk) begin
    if (rst) begin
      div_p_q   <= `RST_DIV;
      div_s_q   <= `RST_DIV;
      in_cfg_q  <= `RST_INPUT_CFG;
      misc_q    <= `RST_REF_MISC;
      sw_q      <= `RST_SWITCH_CTRL;
      coarse_q  <= `RST_FB_COARSE;
      swallow_q <= `RST_FB_SWALLOW;
      m1_q      <= `RST_VCO_DIV_CODE;
      m2_q      <= `RST_VCO_DIV_CODE;
      cal_q     <= 1'b0;
      loop_pd_q <= 1'b0;
    end else if (apply_q) begin
      div_p_q   <= div_p_sh_q;
      div_s_q   <= div_s_sh_q;
      in_cfg_q  <= in_cfg_sh_q;
      misc_q    <= misc_sh_q;
      sw_q      <= sw_sh_q;
      coarse_q  <= coarse_sh_q;
      swallow_q <= swallow_sh_q;
      m1_q      <= m1_sh_q;
      m2_q      <= m2_sh_q;
      cal_q     <= cal_sh_q;
      loop_pd_q <= loop_pd_sh_q;
    end
  end

  // ****************************************************
  // Receiver modes and power gating
  // ****************************************************
  // Differential is the selected receiver while CMOS mode is off
  always @(posedge clk) begin
    if (rst) begin
      cmos_p_q  <= 1'b0;
      cmos_s_q  <= 1'b0;
      dpd_p_q   <= 1'b0;
      dpd_s_q   <= 1'b0;
      spd_p_q   <= 1'b1;
      spd_s_q   <= 1'b1;
      cfg_out_q <= 2'h0;
      osc_pd_q  <= 1'b0;
    end else begin
      cmos_p_q  <= in_cfg_q[`BIT_CMOS_PRIMARY];
      cmos_s_q  <= in_cfg_q[`BIT_CMOS_SECOND];
      dpd_p_q   <= loop_pd_q | in_cfg_q[`BIT_CMOS_PRIMARY];
      dpd_s_q   <= loop_pd_q | in_cfg_q[`BIT_CMOS_SECOND];
      spd_p_q   <= loop_pd_q | sw_q[`BIT_SE_PD_PRIMARY]
                   | ~in_cfg_q[`BIT_CMOS_PRIMARY];
      spd_s_q   <= loop_pd_q | sw_q[`BIT_SE_PD_SECOND]
                   | ~in_cfg_q[`BIT_CMOS_SECOND];
      cfg_out_q <= in_cfg_q[`BIT_OSC_CFG_LO+1:`BIT_OSC_CFG_LO];
      osc_pd_q  <= loop_pd_q;
    end
  end

  // ****************************************************
  // Prescalers and reference monitor, one per input
  // ****************************************************
  assign ratio[0] = div_p_q;
  // Secondary shares the primary ratio unless told otherwise
  assign ratio[1] = misc_q[`BIT_INDEP_DIV] ? div_s_q : div_p_q;

  // Pins are asynchronous: two flops before edge detection
  always @(posedge clk) begin
    if (rst) begin
      ref_s1_q <= 2'b00;
      ref_s2_q <= 2'b00;
      ref_s3_q <= 2'b00;
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
    end else begin
      ref_s1_q <= {ref_input_secondary, ref_input_primary};
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      sel_s1_q <= ref_select_pin;
      sel_s2_q <= sel_s1_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ref
      reg  [9:0]  cnt_q;
      reg  [15:0] idle_q;
      wire        edge_w;
      wire [9:0]  last_w;
      assign edge_w = ref_s2_q[g] & ~ref_s3_q[g];
      // A ratio of zero behaves as divide by one
      assign last_w = (ratio[g] == 10'h000) ? 10'h000
                                            : ratio[g] - 10'h001;
      // Count input edges, pulse once every ratio edges
      always @(posedge clk) begin
        if (rst) begin
          cnt_q          <= 10'h000;
          div_pulse_q[g] <= 1'b0;
        end else if (edge_w) begin
          if (cnt_q >= last_w) begin
            cnt_q          <= 10'h000;
            div_pulse_q[g] <= 1'b1;
          end else begin
            cnt_q          <= cnt_q + 10'h001;
            div_pulse_q[g] <= 1'b0;
          end
        end else begin
          div_pulse_q[g] <= 1'b0;
        end
      end
      // Monitor: lost when no prescaled pulse within the window
      always @(posedge clk) begin
        if (rst) begin
          idle_q       <= 16'h0000;
          present_q[g] <= 1'b0;
        end else if (div_pulse_q[g]) begin
          idle_q       <= 16'h0000;
          present_q[g] <= 1'b1;
        end else if (idle_q >= LOSS_CNT - 16'h0001) begin
          present_q[g] <= 1'b0;
        end else begin
          idle_q       <= idle_q + 16'h0001;
        end
      end
    end
  endgenerate

  // ****************************************************
  // Switchover and holdover
  // ****************************************************
  assign manual_sec = sw_q[`BIT_USE_PIN] ? sel_s2_q
                                         : sw_q[`BIT_MANUAL_SEC];

  // Next active reference from mode and monitor status
  always @* begin
    next_sec = active_sec_q;
    if (!sw_q[`BIT_AUTO_EN]) begin
      next_sec = manual_sec;
    end else if (!active_sec_q) begin
      if (!present_q[0] && present_q[1])
        next_sec = 1'b1;
    end else if (sw_q[`BIT_REVERTIVE]) begin
      if (present_q[0])
        next_sec = 1'b0;
    end else begin
      if (!present_q[1] && present_q[0])
        next_sec = 1'b0;
    end
  end

  // Holdover while both inputs are absent; pump mode from misc
  always @(posedge clk) begin
    if (rst) begin
      active_sec_q <= 1'b0;
      holdover_q   <= 1'b0;
      resync_q     <= 1'b0;
      cp_tri_q     <= 1'b0;
      cp_half_q    <= 1'b0;
    end else begin
      active_sec_q <= next_sec;
      holdover_q   <= ~present_q[0] & ~present_q[1];
      // Loop relocks to whichever reference is now active
      resync_q     <= holdover_q & (present_q[0] | present_q[1]);
      cp_tri_q     <= ~present_q[0] & ~present_q[1]
                      & ~misc_q[`BIT_HOLD_HALF];
      cp_half_q    <= ~present_q[0] & ~present_q[1]
                      & misc_q[`BIT_HOLD_HALF];
    end
  end

  // ****************************************************
  // Output loop divider settings
  // ****************************************************
  // No divider-sync input reaches these ratios; only apply does
  always @(posedge clk) begin
    if (rst) begin
      fb_q       <= 8'h0C;
      m1_ratio_q <= 3'h3;
      m2_ratio_q <= 3'h3;
    end else begin
      fb_q       <= {coarse_q, 2'b00} + {6'h00, swallow_q};
      m1_ratio_q <= 3'h3 + {1'b0, m1_q};
      m2_ratio_q <= 3'h3 + {1'b0, m2_q};
    end
  end

  // ****************************************************
  // VCO calibration
  // ****************************************************
  // Only a rising applied bit starts it; a held 1 does nothing
  always @(posedge clk) begin
    if (rst) begin
      cal_prev_q  <= 1'b0;
      cal_start_q <= 1'b0;
      cal_busy_q  <= 1'b0;
      cal_cnt_q   <= 16'h0000;
    end else begin
      cal_prev_q  <= cal_q;
      cal_start_q <= cal_q & ~cal_prev_q;
      if (cal_q && !cal_prev_q) begin
        cal_busy_q <= 1'b1;
        cal_cnt_q  <= 16'h0000;
      end else if (cal_busy_q) begin
        if (cal_cnt_q >= CAL_CNT - 16'h0001)
          cal_busy_q <= 1'b0;
        else
          cal_cnt_q  <= cal_cnt_q + 16'h0001;
      end
    end
  end
  // ****************************************************
  // Outputs
  // ****************************************************
  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign cmos_primary          = cmos_p_q;
  assign cmos_secondary        = cmos_s_q;
  assign diff_pd_primary       = dpd_p_q;
  assign diff_pd_secondary     = dpd_s_q;
  assign se_pd_primary         = spd_p_q;
  assign se_pd_secondary       = spd_s_q;
  assign osc_rx_cfg            = cfg_out_q;
  assign osc_rx_pd             = osc_pd_q;
  assign div_pulse_primary     = div_pulse_q[0];
  assign div_pulse_secondary   = div_pulse_q[1];
  assign present_primary       = present_q[0];
  assign present_secondary     = present_q[1];
  assign active_secondary      = active_sec_q;
  assign holdover              = holdover_q;
  assign cp_tristate           = cp_tri_q;
  assign cp_half_supply        = cp_half_q;
  assign loop_resync           = resync_q;
  assign fb_ratio              = fb_q;
  assign vco_divider_one_ratio = m1_ratio_q;
  assign vco_divider_two_ratio = m2_ratio_q;
  assign vco_cal_start         = cal_start_q;
  assign vco_cal_busy          = cal_busy_q;

endmodule
